// ==== rtl/conn_entry_decode.sv ====
// Connection entry store and per-slot decoder for a TDM switch.
// Assumes an Avalon-MM master and a frame timer that gives frame_start
// and slot_tick one slot ahead of the slot that the entry serves.
//
// Overview of operation
// R1 - Bit 15 clear: no translation, ignore high half
// R2 - Bit 15 set: translate using high half
// R3 - Bit 14 clear: fetch from constant-delay memory
// R4 - Bit 14 set: fetch from variable-delay memory
// R5 - Software enables variable delay globally first
// R6 - Bits 13..9 give the source stream
// R7 - Bits 8..1 give the source channel
// R8 - Bit 0 clear: normal switching connection
// R9 - Software writes high half before bit 15
// R10 - Bit 0 set: per-channel control entry
// R11 - Each entry read once per frame, before slot
module connection_entry_switch_decode (
  input wire logic mclk, // 20 MHz system clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [11:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic frame_start, // Prefetch slot 0
  input wire logic slot_tick, // Prefetch next slot
  output conn_entry_pkg::route_t fetch, // Decoded entry
  output logic fetch_valid, // Fetch updated, one cycle
  output logic [7:0] fetch_slot // Slot of the fetched entry
);

  logic [15:0] low_mem [conn_entry_pkg::ENTRIES];
  logic [15:0] high_mem [conn_entry_pkg::ENTRIES];
  logic ctrl_q;
  logic rd_pend_q;
  logic [31:0] rdata_q;
  logic [7:0] slot_q;
  logic [7:0] slot_d;
  conn_entry_pkg::route_t fetch_q;
  conn_entry_pkg::route_t fetch_d;
  logic valid_q;

  // Turn one stored entry pair into routing; the global enable gates
  // bit 14 so a stray select cannot reach an idle variable memory.
  function automatic conn_entry_pkg::route_t decode_entry(
    input logic [15:0] lo,
    input logic [15:0] hi,
    input logic var_en
  );
    conn_entry_pkg::route_t r;
    r = '0;
    r.law_en = lo[conn_entry_pkg::LAW_BIT];
    r.law_sel = r.law_en ? hi : 16'h0000;
    r.ctrl_mode = lo[conn_entry_pkg::MODE_BIT];
    if (r.ctrl_mode) begin
      r.pcc = lo[conn_entry_pkg::PCC_MSB:conn_entry_pkg::PCC_LSB];
      r.msg = lo[conn_entry_pkg::MSG_MSB:conn_entry_pkg::MSG_LSB];
    end else begin
      r.var_mem = lo[conn_entry_pkg::VSEL_BIT] & var_en;
      r.stream = lo[conn_entry_pkg::STREAM_MSB:conn_entry_pkg::STREAM_LSB];
      r.chan = lo[conn_entry_pkg::CHAN_MSB:conn_entry_pkg::CHAN_LSB];
    end
    return r;
  endfunction : decode_entry

  // Address decode: pages of one word per entry
  wire [1:0] page_w = avs_address[11:10];
  wire [7:0] idx_w = avs_address[9:2];
  wire is_ctrl_w = avs_address == conn_entry_pkg::CTRL_OFS;
  wire is_stat_w = avs_address == conn_entry_pkg::STATUS_OFS;
  wire is_low_w = page_w == conn_entry_pkg::LOW_PAGE;
  wire is_high_w = page_w == conn_entry_pkg::HIGH_PAGE;
  wire [15:0] be_mask_w = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire wr_low_w = avs_write & is_low_w;
  wire wr_high_w = avs_write & is_high_w;
  wire [15:0] wr_low_val_w = (low_mem[idx_w] & ~be_mask_w)
                             | (avs_writedata[15:0] & be_mask_w);
  wire [15:0] wr_high_val_w = (high_mem[idx_w] & ~be_mask_w)
                              | (avs_writedata[15:0] & be_mask_w);
  // Reads take one wait state so the data comes from a register
  wire rd_take_w = avs_read & ~rd_pend_q;
  wire [31:0] rd_mux_w = is_ctrl_w ? {31'h0000_0000, ctrl_q}
                       : is_stat_w ? {24'h00_0000, slot_q}
                       : is_low_w ? {16'h0000, low_mem[idx_w]}
                       : is_high_w ? {16'h0000, high_mem[idx_w]}
                       : 32'h0000_0000;
  assign avs_waitrequest = rd_take_w;
  assign avs_readdata = rdata_q;

  // Slot sequencing: frame start wins over a tick in the same cycle
  assign slot_d = frame_start ? conn_entry_pkg::SLOT_RST
                : 8'(slot_q + 8'h01);
  wire fetch_en_w = frame_start | slot_tick;
  wire [15:0] entry_lo_w = low_mem[slot_d];
  wire [15:0] entry_hi_w = high_mem[slot_d];
  assign fetch_d = decode_entry(entry_lo_w, entry_hi_w, ctrl_q);
  assign fetch = fetch_q;
  assign fetch_valid = valid_q;
  assign fetch_slot = slot_q;

  // Control register and read pipeline
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rd_pend_q <= rd_take_w;
      if (rd_take_w) begin
        rdata_q <= rd_mux_w;
      end
      if (avs_write & is_ctrl_w & avs_byteenable[0]) begin
        ctrl_q <= avs_writedata[conn_entry_pkg::VAR_EN_BIT];
      end
    end
  end

  // Entry store; no reset on arrays, software programs every slot
  always_ff @(posedge mclk) begin
    if (wr_low_w) begin
      low_mem[idx_w] <= wr_low_val_w;
    end
    if (wr_high_w) begin
      high_mem[idx_w] <= wr_high_val_w;
    end
  end

  // One fetch per slot, so every entry is read once per frame
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slot_q <= conn_entry_pkg::SLOT_RST;
      fetch_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= fetch_en_w; // [R11]
      if (fetch_en_w) begin
        slot_q <= slot_d; // [R11]
        fetch_q <= fetch_d; // [R1] [R2] [R3] [R4] [R6] [R7] [R8] [R10]
      end
    end
  end

  // Helper copies of what the last fetch saw, for the checks below
  logic [15:0] lo_seen_q;
  logic [15:0] hi_seen_q;
  logic en_seen_q;
  logic [7:0] slot_prev_q;
  logic start_seen_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lo_seen_q <= conn_entry_pkg::ENTRY_RST;
      hi_seen_q <= conn_entry_pkg::ENTRY_RST;
      en_seen_q <= 1'b0;
      slot_prev_q <= conn_entry_pkg::SLOT_RST;
      start_seen_q <= 1'b0;
    end else begin
      lo_seen_q <= entry_lo_w;
      hi_seen_q <= entry_hi_w;
      en_seen_q <= ctrl_q;
      slot_prev_q <= slot_q;
      start_seen_q <= frame_start;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_law_off_ignored: assert property (fetch_valid && !fetch.law_en |-> // [R1]
    fetch.law_sel == 16'h0000 && !lo_seen_q[conn_entry_pkg::LAW_BIT])
    else $error("High half leaked with translation off");
  a_law_on_method: assert property (fetch_valid && lo_seen_q[15] |-> // [R2]
    fetch.law_en && fetch.law_sel == hi_seen_q)
    else $error("Translation method not taken from high half");
  a_const_mem_sel: assert property (fetch_valid && !lo_seen_q[14] |-> // [R3]
    !fetch.var_mem)
    else $error("Variable memory chosen with bit 14 clear");
  a_var_mem_sel: assert property (fetch_valid && !lo_seen_q[0] // [R4]
    && lo_seen_q[14] && en_seen_q |-> fetch.var_mem)
    else $error("Variable memory not chosen");
  a_stream_field: assert property (fetch_valid && !fetch.ctrl_mode |-> // [R6]
    fetch.stream == lo_seen_q[13:9])
    else $error("Source stream field wrong");
  a_chan_field: assert property (fetch_valid && !lo_seen_q[0] |-> // [R7]
    fetch.chan == lo_seen_q[8:1])
    else $error("Source channel field wrong");
  a_normal_mode: assert property (fetch_valid && !lo_seen_q[0] |-> // [R8]
    !fetch.ctrl_mode && fetch.pcc == 2'h0 && fetch.msg == 8'h00)
    else $error("Normal entry decoded as control");
  a_ctrl_mode: assert property (fetch_valid && lo_seen_q[0] |-> // [R10]
    fetch.ctrl_mode && fetch.pcc == lo_seen_q[2:1]
    && fetch.msg == lo_seen_q[10:3] && fetch.stream == 5'h00)
    else $error("Control entry decoded wrong");
  a_slot_advance: assert property (slot_tick && !frame_start |=> // [R11]
    fetch_valid && slot_q == 8'(slot_prev_q + 8'h01))
    else $error("Slot did not advance by one");
  a_frame_restart: assert property (frame_start |=> // [R11]
    fetch_valid && slot_q == 8'h00 && start_seen_q)
    else $error("Frame start did not fetch slot 0");
  a_read_one_wait: assert property (avs_read && !rd_pend_q |->
    avs_waitrequest ##1 (!avs_read || !avs_waitrequest))
    else $error("Read not answered after one wait state");

  // Bus handshake: writes never stall, and a read stalls for one cycle only
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("Write was stalled");

  a_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
    else $error("Stall raised with no read pending");

  a_pend_released: assert property (rd_pend_q |-> !avs_waitrequest)
    else $error("Read still stalled in its second cycle");

  a_pend_one_cycle: assert property (rd_pend_q |=> !rd_pend_q)
    else $error("Read pending flag stuck high");

  // Read data only moves when a read is taken, so a slow master sees it hold
  a_rdata_holds: assert property (!(avs_read && !rd_pend_q) |=>
    $stable(avs_readdata))
    else $error("Read data changed without a read");

  a_unmapped_read: assert property (avs_read && !rd_pend_q
    && avs_address[11:10] == 2'h3 |=> avs_readdata == 32'h0000_0000)
    else $error("Unmapped read returned data");

  a_status_read: assert property (avs_read && !rd_pend_q // [R11]
    && avs_address == conn_entry_pkg::STATUS_OFS
    |=> avs_readdata == {24'h00_0000, $past(slot_q)})
    else $error("Status read did not return the slot");

  a_ctrl_readback: assert property (avs_read && !rd_pend_q // [R4]
    && avs_address == conn_entry_pkg::CTRL_OFS
    |=> avs_readdata == {31'h0000_0000, $past(ctrl_q)})
    else $error("Control read did not return the enable");

  // Register writes land at the edge that takes them
  a_ctrl_write_lands: assert property (avs_write // [R4]
    && avs_address == conn_entry_pkg::CTRL_OFS && avs_byteenable[0]
    |=> ctrl_q == $past(avs_writedata[0]))
    else $error("Variable delay enable not written");

  a_low_write_lands: assert property (avs_write && is_low_w
    && avs_byteenable[1:0] == 2'h3
    |=> low_mem[$past(idx_w)] == $past(avs_writedata[15:0]))
    else $error("Low entry write lost");

  a_high_write_lands: assert property (avs_write && is_high_w
    && avs_byteenable[1:0] == 2'h3
    |=> high_mem[$past(idx_w)] == $past(avs_writedata[15:0]))
    else $error("High entry write lost");

  // A write with lane 0 off must leave the low byte alone
  a_lane0_kept: assert property (avs_write && is_low_w && !avs_byteenable[0]
    |=> low_mem[$past(idx_w)][7:0] == $past(low_mem[idx_w][7:0]))
    else $error("Disabled byte lane was written");

  // Fetch side: outputs move only on a pulse, one strobe per pulse
  a_fetch_holds: assert property (!frame_start && !slot_tick |=> // [R11]
    $stable(fetch))
    else $error("Fetched route changed without a pulse");

  a_slot_holds: assert property (!frame_start && !slot_tick |=> // [R11]
    $stable(fetch_slot))
    else $error("Slot changed without a pulse");

  a_valid_only_pulse: assert property (!frame_start && !slot_tick |=> // [R11]
    !fetch_valid)
    else $error("Fetch strobe without a pulse");

  a_valid_after_tick: assert property (slot_tick |=> fetch_valid) // [R11]
    else $error("Tick gave no fetch strobe");

  a_slot_wrap: assert property (slot_tick && !frame_start // [R11]
    && slot_q == 8'hff |=> slot_q == 8'h00)
    else $error("Slot did not wrap to zero");

  // Decoded route against the entry that the fetch saw
  a_law_bit_follows: assert property (fetch_valid |-> // [R1] [R2]
    fetch.law_en == lo_seen_q[conn_entry_pkg::LAW_BIT])
    else $error("Translation enable not taken from bit 15");

  a_var_needs_bits: assert property (fetch_valid && fetch.var_mem |-> // [R4]
    lo_seen_q[14] && en_seen_q && !lo_seen_q[0])
    else $error("Variable memory chosen without cause");

  a_var_gated_off: assert property (fetch_valid && !en_seen_q |-> // [R3]
    !fetch.var_mem)
    else $error("Variable memory chosen while globally off");

  a_ctrl_no_route: assert property (fetch_valid && lo_seen_q[0] |-> // [R10]
    fetch.chan == 8'h00 && !fetch.var_mem)
    else $error("Control entry left routing fields set");

  a_high_ignored: assert property (fetch_valid && !lo_seen_q[15] |-> // [R1]
    fetch.law_sel == 16'h0000)
    else $error("High half used with translation off");

endmodule : connection_entry_switch_decode

// ==== rtl/conn_entry_pkg.sv ====
// Constants and carrier types for the connection entry decoder.
// Assumes a 16-bit entry layout and a 256-slot frame per output stream.
package conn_entry_pkg;
  // Entry memory depth and index width
  localparam int ENTRY_AW = 8;
  localparam int ENTRIES = 256;
  // Register byte offsets and entry page numbers on the slave port
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [1:0] LOW_PAGE = 2'h1;
  localparam logic [1:0] HIGH_PAGE = 2'h2;
  // Field positions of the low-half entry and the control register enable bit
  localparam int LAW_BIT = 15;
  localparam int VSEL_BIT = 14;
  localparam int STREAM_MSB = 13;
  localparam int STREAM_LSB = 9;
  localparam int CHAN_MSB = 8;
  localparam int CHAN_LSB = 1;
  localparam int MODE_BIT = 0;
  localparam int PCC_MSB = 2;
  localparam int PCC_LSB = 1;
  localparam int MSG_MSB = 10;
  localparam int MSG_LSB = 3;
  localparam int VAR_EN_BIT = 0;
  // Reset values
  localparam logic [15:0] ENTRY_RST = 16'h0000;
  localparam logic [ENTRY_AW-1:0] SLOT_RST = 8'h00;

  // Decoded routing for one output channel
  typedef struct packed {
    logic law_en;
    logic var_mem;
    logic ctrl_mode;
    logic [1:0] pcc;
    logic [7:0] msg;
    logic [4:0] stream;
    logic [7:0] chan;
    logic [15:0] law_sel;
  } route_t;
endpackage : conn_entry_pkg

// ==== verification/connection_entry_switch_decode_tb.sv ====
// Self-checking bench for the connection entry decoder.
// Assumes one read wait state, zero-wait writes and one-cycle fetch latency.
module connection_entry_switch_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, avs_read, avs_write, frame_start, slot_tick, avs_waitrequest, fetch_valid;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [7:0] fetch_slot;
  conn_entry_pkg::route_t fetch;
  int fails, n_tests, cyc;

  connection_entry_switch_decode connection_entry_switch_decode_inst (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .frame_start(frame_start), .slot_tick(slot_tick), .fetch(fetch),
    .fetch_valid(fetch_valid), .fetch_slot(fetch_slot)
  );

  // 20 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Cycle ceiling, so a stuck handshake still reaches the report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("n_tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // Widened so one compare serves routes, slots and bus words
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One bus cycle; an edge passes after release so back-to-back calls never collide
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : bus

  // Prefetch pulse, then look at the one-cycle fetch strobe
  task automatic pulse(input logic frame);
    frame_start <= frame;
    slot_tick <= !frame;
    @(posedge mclk);
    frame_start <= 1'b0;
    slot_tick <= 1'b0;
    @(posedge mclk);
    cmp(fetch_valid, 1'b1);
  endtask : pulse

  function automatic conn_entry_pkg::route_t mk(logic l, logic v, logic c, logic [1:0] p,
      logic [7:0] m, logic [4:0] s, logic [7:0] ch, logic [15:0] h);
    mk = {l, v, c, p, m, s, ch, h};
  endfunction : mk

  task automatic t_switch;
    bus(1, 12'h000, 32'h0000_0001);
    bus(1, 12'h800, 32'h0000_1234);
    bus(1, 12'h400, 32'h0000_ff4a);
    pulse(1);
    cmp(fetch, mk(1, 1, 0, 2'h0, 8'h00, 5'h1f, 8'ha5, 16'h1234));
    cmp(fetch_slot, 8'h00);
  endtask : t_switch

  task automatic t_plain;
    bus(1, 12'h000, 32'h0000_0000);
    bus(1, 12'h804, 32'h0000_ffff);
    bus(1, 12'h404, 32'h0000_42b4);
    pulse(0);
    cmp(fetch, mk(0, 0, 0, 2'h0, 8'h00, 5'h01, 8'h5a, 16'h0000));
    cmp(fetch_slot, 8'h01);
  endtask : t_plain

  task automatic t_ctrl;
    bus(1, 12'h808, 32'h0000_00ff);
    bus(1, 12'h408, 32'h0000_81e3);
    pulse(0);
    cmp(fetch, mk(1, 0, 1, 2'h1, 8'h3c, 5'h00, 8'h00, 16'h00ff));
    cmp(fetch_slot, 8'h02);
  endtask : t_ctrl

  // Read back, unmapped read, then a rewrite seen at the next frame
  task automatic t_update;
    bus(0, 12'h408, 32'h0000_0000);
    cmp(rd, 32'h0000_81e3);
    bus(0, 12'hffc, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    bus(1, 12'h400, 32'h0000_0002);
    pulse(1);
    cmp(fetch, mk(0, 0, 0, 2'h0, 8'h00, 5'h00, 8'h01, 16'h0000));
  endtask : t_update

  // Status, control, lane-masked write, then a reset in mid-run
  task automatic t_regs;
    bus(0, 12'h004, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    bus(0, 12'h000, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    bus(1, 12'h40c, 32'h0000_1100);
    avs_byteenable <= 4'h2;
    bus(1, 12'h40c, 32'h0000_ab12);
    avs_byteenable <= 4'hf;
    bus(0, 12'h40c, 32'h0000_0000);
    cmp(rd, 32'h0000_ab00);
    pulse(0);
    cmp(fetch_slot, 8'h01);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    cmp(fetch_slot, 8'h00);
    cmp(fetch_valid, 1'b0);
    resetn <= 1'b1;
    @(posedge mclk);
  endtask : t_regs

  // Main sequence
  initial begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    frame_start = 1'b0;
    slot_tick = 1'b0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_switch();
    t_plain();
    t_ctrl();
    t_update();
    t_regs();
    end_of_test();
  end
endmodule : connection_entry_switch_decode_tb
